// ==== core/pwmct_defs.svh ====
/*
 * Register offsets, field positions, reset values and bus codes of the
 * PWM channel timer. Assumes a 32-bit AXI4-Lite bus with byte offsets.
 */
`ifndef PWMCT_DEFS_SVH
`define PWMCT_DEFS_SVH

// Register byte offsets.
`define PWMCT_OFF_CTRL   8'h00
`define PWMCT_OFF_PERIOD 8'h04
`define PWMCT_OFF_DUTY   8'h08
`define PWMCT_OFF_COUNT  8'h0C
`define PWMCT_OFF_STATUS 8'h10

// Control register field positions.
`define PWMCT_CTRL_EN    0
`define PWMCT_CTRL_POL   1
`define PWMCT_CTRL_CAE   2

// Reset values.
`define PWMCT_RST_BYTE   8'h00
`define PWMCT_RST_DATA   32'h0000_0000

// Bus response codes.
`define PWMCT_RESP_OKAY   2'b00
`define PWMCT_RESP_SLVERR 2'b10

`endif

// ==== core/pwmct_pkg.sv ====
/*
 * Types of the PWM channel timer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pwmct_pkg;
  typedef logic [7:0] pwmct_byte_t;
  typedef enum logic [0:0] {
    PWMCT_DIR_UP   = 1'b0,
    PWMCT_DIR_DOWN = 1'b1
  } pwmct_dir_t;
endpackage

// ==== core/pwmct_dbuf.sv ====
/*
 * Double-buffered byte: a buffer that software writes and an active latch
 * that the counter compares against. Assumes clk and a synchronous reset.
 */
module pwmct_dbuf #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         wr,
  input  wire logic [W-1:0] wdata,
  input  wire logic         load,
  output logic      [W-1:0] buf_q,
  output logic      [W-1:0] act_q
);

  // The buffer takes every software write.
  always_ff @(posedge clk) begin
    if (reset) begin
      buf_q <= '0;
    end else if (wr) begin
      buf_q <= wdata;
    end
  end

  // The latch copies the buffer on a load; a write in the same cycle wins.
  always_ff @(posedge clk) begin
    if (reset) begin
      act_q <= '0;
    end else if (load) begin
      act_q <= wr ? wdata : buf_q;
    end
  end

endmodule

// ==== core/pwmct_run_sync.sv ====
/*
 * Enable resynchroniser: the enable bit reaches the counter only on a tick of
 * the selected clock. Assumes tick is a one-cycle pulse on clk.
 */
module pwmct_run_sync (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic tick,
  input  wire logic en,
  output logic      run_q
);

  // The running state changes only at the edge of the selected clock.
  always_ff @(posedge clk) begin
    if (reset) begin
      run_q <= 1'b0;
    end else if (tick) begin
      run_q <= en;
    end
  end

endmodule

// ==== core/pwmct_top.sv ====
/*
 * PWM channel timer with an AXI4-Lite register slave: 8-bit up/down counter,
 * double-buffered period and duty, selectable start polarity and alignment.
 * Assumes tick is a one-cycle pulse on clk from the prescaler logic.
 */
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
// Operation
// - Running channel buffers new period and duty
// - Disabled channel writes buffer and latch together
// - Duty sets high or low time by polarity
// - Own 8-bit up/down counter advancing per tick
// - Counter equal to duty toggles output flip-flop
// - Counter reads never disturb the channel
// - Counter write clears, counts up, loads, repolarises
// - Disabled counter holds, resumes from held value
// - Disabled with zero period clears counter next tick
// - Running counter write starts new period at once
// - Counter clears at end of effective period
// - Alignment bit selects left or center mode
// - Left mode counts up, period match restarts
// - Left mode period equals period ticks
// - Left mode high fraction follows polarity
// - Center mode direction forced up at zero
// - Center period match reverses, duty toggles again
// - Center down to zero turns up, loads
// - Center effective period twice period value
// - Polarity sets starting level of each cycle
// - Waveform starts at next selected clock cycle
`include "pwmct_defs.svh"

module pwmct_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              tick,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   pwm_q
);
  import pwmct_pkg::*;

  logic              aw_have_q;
  logic              w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              commit;
  logic              lane0;
  logic              hit_ctrl;
  logic              hit_per;
  logic              hit_dty;
  logic              hit_cnt;
  logic              hit_stat;
  logic              wr_ctrl;
  logic              wr_per;
  logic              wr_dty;
  logic              cnt_wr;
  logic              en_q;
  logic              pol_q;
  logic              cae_q;
  logic              run_q;
  pwmct_byte_t       per_buf;
  pwmct_byte_t       per_act;
  pwmct_byte_t       dty_buf;
  pwmct_byte_t       dty_act;
  pwmct_byte_t       cnt_q;
  pwmct_byte_t       cnt_d;
  pwmct_dir_t        dir_q;
  pwmct_dir_t        dir_d;
  logic              ff_q;
  logic              ff_d;
  logic              load_end;
  logic              load;
  logic [31:0]       rd_mux;
  logic              rd_ok;

  //////////////////////////////////////////////////////////////////////////////
  // Register bus slave.

  // Write address and data are taken in either order and held until commit.
  assign commit = aw_have_q && w_have_q && !s_axi_bvalid;
  assign lane0  = w_strb_q[0];

  // Address channel holding register.
  always_ff @(posedge clk) begin
    if (reset) begin
      aw_have_q     <= 1'b0;
      s_axi_awready <= 1'b1;
      aw_addr_q     <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q     <= 1'b1;
      s_axi_awready <= 1'b0;
      aw_addr_q     <= s_axi_awaddr;
    end else if (commit) begin
      aw_have_q     <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  // Data channel holding register.
  always_ff @(posedge clk) begin
    if (reset) begin
      w_have_q     <= 1'b0;
      s_axi_wready <= 1'b1;
      w_data_q     <= `PWMCT_RST_DATA;
      w_strb_q     <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q     <= 1'b1;
      s_axi_wready <= 1'b0;
      w_data_q     <= s_axi_wdata;
      w_strb_q     <= s_axi_wstrb;
    end else if (commit) begin
      w_have_q     <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // Address decode of the held write address.
  assign hit_ctrl = aw_addr_q == ADDR_W'(`PWMCT_OFF_CTRL);
  assign hit_per  = aw_addr_q == ADDR_W'(`PWMCT_OFF_PERIOD);
  assign hit_dty  = aw_addr_q == ADDR_W'(`PWMCT_OFF_DUTY);
  assign hit_cnt  = aw_addr_q == ADDR_W'(`PWMCT_OFF_COUNT);
  assign hit_stat = aw_addr_q == ADDR_W'(`PWMCT_OFF_STATUS);
  assign wr_ctrl  = commit && hit_ctrl && lane0;
  assign wr_per   = commit && hit_per && lane0;
  assign wr_dty   = commit && hit_dty && lane0;
  assign cnt_wr   = commit && hit_cnt && lane0;

  // Write response; unmapped addresses answer SLVERR.
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PWMCT_RESP_OKAY;
    end else if (commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (hit_ctrl || hit_per || hit_dty || hit_cnt || hit_stat) ?
                      `PWMCT_RESP_OKAY : `PWMCT_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read mux; the status word shows running state, direction and output.
  always_comb begin
    rd_mux = `PWMCT_RST_DATA;
    rd_ok  = 1'b1;
    unique case (s_axi_araddr)
      ADDR_W'(`PWMCT_OFF_CTRL):   rd_mux = {29'h0, cae_q, pol_q, en_q};
      ADDR_W'(`PWMCT_OFF_PERIOD): rd_mux = {24'h0, per_buf};
      ADDR_W'(`PWMCT_OFF_DUTY):   rd_mux = {24'h0, dty_buf};
      ADDR_W'(`PWMCT_OFF_COUNT):  rd_mux = {24'h0, cnt_q};
      ADDR_W'(`PWMCT_OFF_STATUS): rd_mux = {29'h0, pwm_q, dir_q, run_q};
      default:                    rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `PWMCT_RST_DATA;
      s_axi_rresp   <= `PWMCT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_ok ? `PWMCT_RESP_OKAY : `PWMCT_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channel control.

  // Enable, start polarity and alignment bits.
  always_ff @(posedge clk) begin
    if (reset) begin
      en_q  <= 1'b0;
      pol_q <= 1'b0;
      cae_q <= 1'b0;
    end else if (wr_ctrl) begin
      en_q  <= w_data_q[`PWMCT_CTRL_EN];
      pol_q <= w_data_q[`PWMCT_CTRL_POL];
      cae_q <= w_data_q[`PWMCT_CTRL_CAE];
    end
  end

  pwmct_run_sync u_run (
    .clk   (clk),
    .reset (reset),
    .tick  (tick),
    .en    (en_q),
    .run_q (run_q)
  );

  assign load = load_end || cnt_wr || !run_q;

  pwmct_dbuf #(.W(8)) u_per (
    .clk   (clk),
    .reset (reset),
    .wr    (wr_per),
    .wdata (w_data_q[7:0]),
    .load  (load),
    .buf_q (per_buf),
    .act_q (per_act)
  );

  pwmct_dbuf #(.W(8)) u_dty (
    .clk   (clk),
    .reset (reset),
    .wr    (wr_dty),
    .wdata (w_data_q[7:0]),
    .load  (load),
    .buf_q (dty_buf),
    .act_q (dty_act)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Counter and output flip-flop.

  // Next count, direction and output state, updated on ticks and on counter writes.
  always_comb begin
    cnt_d    = cnt_q;
    dir_d    = dir_q;
    ff_d     = ff_q;
    load_end = 1'b0;
    if (cnt_wr) begin
      cnt_d = 8'h00;
      dir_d = PWMCT_DIR_UP;
      ff_d  = 1'b0;
    end else if (tick) begin
      if (!run_q) begin
        if (per_act == 8'h00) begin
          cnt_d = 8'h00;
          dir_d = PWMCT_DIR_UP;
        end
      end else if (per_act == 8'h00) begin
        cnt_d = 8'h00;
        dir_d = PWMCT_DIR_UP;
        ff_d  = 1'b0;
      end else if (!cae_q) begin
        if (cnt_q + 8'h01 == per_act) begin
          cnt_d    = 8'h00;
          dir_d    = PWMCT_DIR_UP;
          ff_d     = (dty_act == 8'h00);
          load_end = 1'b1;
        end else begin
          cnt_d = cnt_q + 8'h01;
          if (cnt_d == dty_act) begin
            ff_d = ~ff_q;
          end
        end
      end else if (dir_q == PWMCT_DIR_UP) begin
        cnt_d = cnt_q + 8'h01;
        if (cnt_d == per_act) begin
          dir_d = PWMCT_DIR_DOWN;
        end
        if (cnt_d == dty_act) begin
          ff_d = ~ff_q;
        end
      end else begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_d == dty_act) begin
          ff_d = ~ff_q;
        end
        if (cnt_d == 8'h00) begin
          dir_d    = PWMCT_DIR_UP;
          load_end = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= `PWMCT_RST_BYTE;
      dir_q <= PWMCT_DIR_UP;
      ff_q  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
      ff_q  <= ff_d;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= ff_d ^ pol_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_cnt_write;
    cnt_wr;
  endsequence

  sequence s_restart;
    (cnt_q == 8'h00) && (dir_q == PWMCT_DIR_UP) && (pwm_q == $past(pol_q));
  endsequence

  // Counter write restarts the period with the polarity level.
  AST_CNT_WR_RESTART: assert property (s_cnt_write |=> s_restart)
    else $error("counter write did not restart the period");

  // Without a tick or a counter write the count never moves.
  AST_NO_TICK_HOLD: assert property (!tick && !cnt_wr |=> $stable(cnt_q))
    else $error("counter moved without a tick");

  // A disabled channel with a nonzero period holds its count.
  AST_DISABLED_HOLD: assert property (
    tick && !run_q && per_act != 8'h00 && !cnt_wr |=> $stable(cnt_q))
    else $error("disabled counter did not hold");

  // Left aligned counting goes up by one until the period match.
  AST_LEFT_UP: assert property (
    tick && run_q && !cae_q && !cnt_wr && per_act != 8'h00 &&
    cnt_q + 8'h01 != per_act |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("left aligned counter did not increment");

  // Left aligned period match clears the counter.
  AST_LEFT_END: assert property (
    tick && run_q && !cae_q && !cnt_wr && per_act != 8'h00 &&
    cnt_q + 8'h01 == per_act |=> cnt_q == 8'h00)
    else $error("period end did not clear the counter");

  // A running channel keeps its active values until a load.
  AST_BUFFER_WAIT: assert property (
    run_q && !load |=> $stable(per_act) && $stable(dty_act))
    else $error("active value changed while buffered");

  // A disabled channel takes a period write into the latch at once.
  AST_DISABLED_LATCH: assert property (
    wr_per && !run_q |=> per_act == $past(w_data_q[7:0]))
    else $error("disabled period write missed the latch");

  // A zero count always runs upward.
  AST_ZERO_UP: assert property (cnt_q == 8'h00 |-> dir_q == PWMCT_DIR_UP)
    else $error("zero count not set to count up");

  // Center mode turns down at the period value.
  AST_CENTER_TURN: assert property (
    tick && run_q && cae_q && !cnt_wr && dir_q == PWMCT_DIR_UP &&
    per_act != 8'h00 && cnt_q + 8'h01 == per_act |=> dir_q == PWMCT_DIR_DOWN)
    else $error("center counter did not reverse");

  // Duty match moves the output away from the polarity level.
  AST_DUTY_TOGGLE: assert property (
    tick && run_q && !cae_q && !cnt_wr && per_act != 8'h00 &&
    cnt_q + 8'h01 != per_act && cnt_q + 8'h01 == dty_act
    |=> pwm_q != $past(pwm_q) || $changed(pol_q))
    else $error("duty match did not toggle the output");

  // The write response stands until it is taken.
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");

endmodule

// ==== verification/test_pwm_channel_timer.sv ====
/*
 * Self-checking bench of the PWM channel timer: AXI4-Lite tasks, a tick
 * driver and a reference model whose expectations a monitor compares.
 * Assumes pwmct_defs.svh on the include path and the core files compiled.
 */
`include "pwmct_defs.svh"

module test_pwm_channel_timer;
  timeunit 1ns;
  timeprecision 1ps;
  import pwmct_pkg::*;

  logic        clk;
  logic        reset;
  logic        tick;
  logic [7:0]  s_axi_awaddr;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        pwm_q;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [33:0] exp_q;
  int          fails;
  int          total_checks;
  int          cycles;
  int          cnt, dir, ff, run, en, pol, cae, pbuf, pact, dbuf, dact, per, du;

  pwmct_top dut (.clk(clk), .reset(reset), .tick(tick), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pwm_q(pwm_q));

  ////////////////////////////////////////////////////////////////////////////
  // Clock of 4 ns period.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Reference model: advances the channel by one selected-clock tick.
  function automatic void step();
    if (run != 0) begin
      if (pact == 0) begin
        cnt = 0;
      end else if (cae == 0) begin
        if (cnt + 1 == pact) begin
          cnt = 0;
          pact = pbuf;
          dact = dbuf;
          ff = 0;
        end else begin
          cnt++;
          if (cnt == dact) ff ^= 1;
        end
      end else begin
        cnt = (dir == 0) ? cnt + 1 : cnt - 1;
        if (dir == 0 && cnt == pact) begin
          dir = 1;
        end else if (dir == 1 && cnt == 0) begin
          dir = 0;
          pact = pbuf;
          dact = dbuf;
        end
        if (cnt == dact) ff ^= 1;
      end
    end else if (pact == 0) begin
      cnt = 0;
    end
    run = en;
    // A stopped channel lets its latches follow the buffers.
    if (run == 0) begin
      pact = pbuf;
      dact = dbuf;
    end
  endfunction

  // Reference model: effect of an accepted register write.
  function automatic void mwr(logic [7:0] a, logic [31:0] d);
    case (a)
      `PWMCT_OFF_CTRL: begin
        en = d[0];
        pol = d[1];
        cae = d[2];
      end
      `PWMCT_OFF_PERIOD: begin
        pbuf = d[7:0];
        if (run == 0) pact = pbuf;
      end
      `PWMCT_OFF_DUTY: begin
        dbuf = d[7:0];
        if (run == 0) dact = dbuf;
      end
      `PWMCT_OFF_COUNT: begin
        cnt = 0;
        dir = 0;
        ff = 0;
        pact = pbuf;
        dact = dbuf;
      end
      default: ;
    endcase
  endfunction

  function automatic logic [31:0] stat();
    return {29'h0000_0000, 1'(ff ^ pol), 1'(dir), 1'(run)};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write: address and data offered together, response awaited with bready.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    bit ad;
    bit wd;
    @(posedge clk);
    bq.push_back(er);
    ad = 0;
    wd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (ad && wd && s_axi_bvalid) break;
      if (!ad && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b0;
    if (s[0] && er == `PWMCT_RESP_OKAY) mwr(a, d);
  endtask

  // Read: expected word noted first, the monitor compares it.
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    bit ad;
    @(posedge clk);
    rq.push_back({er, e});
    ad = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (ad && s_axi_rvalid) break;
      if (!ad && s_axi_arready) begin
        ad = 1;
        s_axi_arvalid <= 1'b0;
      end
    end
    s_axi_rready <= 1'b0;
  endtask

  // One-cycle tick pulse followed by a random idle gap.
  task automatic tk();
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    step();
    repeat (1 + $urandom_range(0, 2)) @(posedge clk);
  endtask

  task automatic chk_all();
    rd(`PWMCT_OFF_COUNT, 32'(cnt), `PWMCT_RESP_OKAY);
    rd(`PWMCT_OFF_STATUS, stat(), `PWMCT_RESP_OKAY);
  endtask

  task automatic tally_and_finish();
    if (fails == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Monitor: takes the oldest note whenever a response appears.
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      exp_q = rq.pop_front();
      total_checks++;
      if ({s_axi_rresp, s_axi_rdata} !== exp_q) begin
        fails++;
        $display("ERROR t=%0t got=%h exp=%h", $time, {s_axi_rresp, s_axi_rdata}, exp_q);
      end
    end
    if (s_axi_bvalid && s_axi_bready) begin
      exp_q = 34'(bq.pop_front());
      total_checks++;
      if (s_axi_bresp !== exp_q[1:0]) begin
        fails++;
        $display("ERROR t=%0t got=%h exp=%h", $time, s_axi_bresp, exp_q[1:0]);
      end
    end
  end

  // Watchdog against a hung handshake.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {tick, s_axi_awaddr, s_axi_araddr, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_wdata, s_axi_wstrb, s_axi_arvalid, s_axi_rready} = '0;
    {fails, total_checks, cycles, cnt, dir, ff, run, en, pol, cae, pbuf, pact, dbuf, dact} = '0;
    reset = 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    void'($urandom(88130));
    for (int a = 0; a < 5; a++) rd(8'(4 * a), 32'h0000_0000, `PWMCT_RESP_OKAY);
    rd(8'h14, 32'h0000_0000, `PWMCT_RESP_SLVERR);
    wr(8'h14, 32'h0000_00FF, 4'hF, `PWMCT_RESP_SLVERR);
    wr(`PWMCT_OFF_STATUS, 32'h0000_0007, 4'hF, `PWMCT_RESP_OKAY);
    for (int m = 0; m < 4; m++) begin
      per = $urandom_range(3, 9);
      du = $urandom_range(1, per - 1);
      wr(`PWMCT_OFF_CTRL, 32'(m * 2), 4'hF, `PWMCT_RESP_OKAY);
      wr(`PWMCT_OFF_PERIOD, 32'(per), 4'hF, `PWMCT_RESP_OKAY);
      wr(`PWMCT_OFF_DUTY, 32'(du), 4'hF, `PWMCT_RESP_OKAY);
      wr(`PWMCT_OFF_COUNT, $urandom, 4'hF, `PWMCT_RESP_OKAY);
      chk_all();
      wr(`PWMCT_OFF_CTRL, 32'(m * 2 + 1), 4'hF, `PWMCT_RESP_OKAY);
      for (int k = 0; k < 2 * per + 2; k++) begin
        if (k == per) wr(`PWMCT_OFF_PERIOD, 32'(per + 1), 4'hF, `PWMCT_RESP_OKAY);
        tk();
        chk_all();
      end
      rd(`PWMCT_OFF_PERIOD, 32'(per + 1), `PWMCT_RESP_OKAY);
      wr(`PWMCT_OFF_COUNT, 32'h0000_00A5, 4'hF, `PWMCT_RESP_OKAY);
      chk_all();
      tk();
      chk_all();
      wr(`PWMCT_OFF_CTRL, 32'(m * 2), 4'hF, `PWMCT_RESP_OKAY);
      repeat (3) begin
        tk();
        chk_all();
      end
      chk_all();
      wr(`PWMCT_OFF_CTRL, 32'(m * 2 + 1), 4'hF, `PWMCT_RESP_OKAY);
      tk();
      tk();
      chk_all();
      wr(`PWMCT_OFF_CTRL, 32'(m * 2), 4'hF, `PWMCT_RESP_OKAY);
      tk();
    end
    wr(`PWMCT_OFF_PERIOD, 32'h0000_0000, 4'hF, `PWMCT_RESP_OKAY);
    chk_all();
    tk();
    chk_all();
    wr(`PWMCT_OFF_PERIOD, 32'h0000_0055, 4'h0, `PWMCT_RESP_OKAY);
    rd(`PWMCT_OFF_PERIOD, 32'h0000_0000, `PWMCT_RESP_OKAY);
    tally_and_finish();
  end
endmodule
